// ===== bench/cpso_prom_model.sv
/*
  Behavioural model of the serial configuration EEPROM at the far side of the block.
  Assumes a pull-up on the data line and clean, registered serial clock edges.
*/
`timescale 1ns/1ps
module cpso_prom_model (
  input wire logic rstn,
  input wire logic prom_clock_line,
  input wire logic prom_data_out,
  input wire logic prom_data_oe,
  input wire logic ack_en,
  output logic data_line,
  output logic [7:0] byte_out,
  output logic [15:0] rise_cnt
);
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic pull_low_q;

  // A released line floats to the pull-up level, so the model can only ever pull low.
  assign data_line = (prom_data_oe ? prom_data_out : 1'b1) & ~pull_low_q;

  always_ff @(posedge prom_clock_line or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      byte_out <= 8'h00;
      rise_cnt <= 16'h0000;
    end else begin
      rise_cnt <= rise_cnt + 16'h0001;
      if (bit_cnt_q == 4'h8) begin
        bit_cnt_q <= 4'h0;
        byte_out <= shift_q;
      end else begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        shift_q <= {shift_q[6:0], data_line};
      end
    end
  end

  // The acknowledge is held from the fall after the eighth bit to the fall after the ninth.
  always_ff @(negedge prom_clock_line or negedge rstn) begin
    if (!rstn) begin
      pull_low_q <= 1'b0;
    end else begin
      pull_low_q <= ack_en && (bit_cnt_q == 4'h8);
    end
  end
endmodule // cpso_prom_model

// ===== bench/cpso_top_tb.sv
/*
  Self-checking testbench of the override bits and byte engine.
  Assumes the EEPROM model beside it and the register offsets of the shared header.
*/
`timescale 1ns/1ps
`include "cpso_defines.svh"
module cpso_top_tb;
  import cpso_pkg::*;
  typedef struct packed {
    cpso_word_t wdata;
    cpso_word_t rexp;
    logic clk;
    logic oe;
    logic dout;
  } cpso_row_s;
  localparam int PER = `CPSO_PHASES * `CPSO_TICK_CYCLES;
  localparam int LIMIT = 40000;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  cpso_addr_t reg_addr = 8'h00;
  cpso_word_t reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  cpso_word_t reg_rdata;
  logic data_line;
  logic prom_clock_line;
  logic prom_data_out;
  logic prom_data_oe;
  logic prom_access_enable;
  logic ack_en = 1'b1;
  logic [7:0] byte_out;
  logic [15:0] rise_cnt;
  logic clk_prev = 1'b0;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  int last_rise = 0;
  int clk_per = 0;
  cpso_byte_t bytes [4] = '{8'hA5, 8'h5A, 8'h81, 8'h3C};
  cpso_row_s rows [7] = '{
    '{32'h00000080, 32'h00000CC0, 1'b0, 1'b0, 1'b1},
    '{32'h00000100, 32'h00000140, 1'b0, 1'b1, 1'b0},
    '{32'h00000300, 32'h00000340, 1'b1, 1'b1, 1'b0},
    '{32'h00000500, 32'h00000D40, 1'b0, 1'b1, 1'b1},
    '{32'h00000700, 32'h00000F40, 1'b1, 1'b1, 1'b1},
    '{32'h00000000, 32'h00000C40, 1'b0, 1'b0, 1'b1},
    '{32'h00000780, 32'h00000FC0, 1'b1, 1'b1, 1'b1}
  };
  // A page of 256 data and 4 address bytes must land within 25 ms of host cycles.
  localparam int PAGE_BYTES = 260;
  localparam int PAGE_CYCLES = 1000000;

  cpso_top uut (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .prom_data_in(data_line),
    .prom_clock_line(prom_clock_line),
    .prom_data_out(prom_data_out),
    .prom_data_oe(prom_data_oe),
    .prom_access_enable(prom_access_enable)
  );

  cpso_prom_model prom (
    .rstn(rstn),
    .prom_clock_line(prom_clock_line),
    .prom_data_out(prom_data_out),
    .prom_data_oe(prom_data_oe),
    .ack_en(ack_en),
    .data_line(data_line),
    .byte_out(byte_out),
    .rise_cnt(rise_cnt)
  );

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  // The bit period is measured between serial clock rises, counted in host cycles.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    clk_prev <= prom_clock_line;
    if (prom_clock_line && !clk_prev) begin
      clk_per <= cyc - last_rise;
      last_rise <= cyc;
    end
    if (cyc == LIMIT) begin
      fails++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input cpso_word_t seen, input cpso_word_t exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input cpso_addr_t a, input cpso_word_t d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input cpso_addr_t a, output cpso_word_t d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic do_reset();
    cpso_word_t v;
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(`CPSO_CMD_OFF, v);
    chk(v, 32'h00000C40);
    chk(cpso_word_t'({prom_clock_line, prom_data_oe, prom_access_enable}), 32'h0);
  endtask

  task automatic wait_idle(output cpso_word_t v);
    int n;
    n = 0;
    rd(`CPSO_CMD_OFF, v);
    while (v[`CPSO_BIT_WBUSY] !== 1'b0 && n < 3000) begin
      rd(`CPSO_CMD_OFF, v);
      n++;
    end
  endtask

  initial begin
    cpso_word_t v;
    logic [15:0] r0;
    int t0;
    do_reset();
    foreach (rows[i]) begin
      wr(`CPSO_CMD_OFF, rows[i].wdata);
      repeat (4) @(posedge sys_clk);
      rd(`CPSO_CMD_OFF, v);
      chk(v, rows[i].rexp);
      chk(cpso_word_t'(prom_clock_line), cpso_word_t'(rows[i].clk));
      chk(cpso_word_t'(prom_data_out), cpso_word_t'(rows[i].dout));
      chk(cpso_word_t'(prom_data_oe), cpso_word_t'(rows[i].oe));
      chk(cpso_word_t'(prom_access_enable), cpso_word_t'(rows[i].wdata[`CPSO_BIT_EN]));
    end
    // A second reset in mid-run also clears the model's bit count after manual toggling.
    do_reset();
    rd(8'h08, v);
    chk(v, 32'h00000000);
    @(posedge sys_clk);
    #1;
    chk(reg_rdata, 32'h00000000);
    for (int i = 0; i < 4; i++) begin
      wr(`CPSO_WDATA_OFF, cpso_word_t'(bytes[i]));
    end
    wr(`CPSO_WDATA_OFF, 32'h000000FF);
    rd(`CPSO_WDATA_OFF, v);
    chk(v, {23'h0, 1'b1, bytes[3]});
    for (int i = 0; i < 4; i++) begin
      ack_en <= (i != 3);
      r0 = rise_cnt;
      t0 = cyc;
      wr(`CPSO_CMD_OFF, 32'h00000088);
      rd(`CPSO_CMD_OFF, v);
      chk(cpso_word_t'(v[`CPSO_BIT_WBUSY]), 32'h1);
      wait_idle(v);
      chk(v & 32'h00000048, (i == 3) ? 32'h00000040 : 32'h00000000);
      chk(cpso_word_t'(byte_out), cpso_word_t'(bytes[i]));
      chk(cpso_word_t'(rise_cnt - r0), 32'h9);
      chk(cpso_word_t'(PAGE_BYTES * (cyc - t0) <= PAGE_CYCLES), 32'h1);
    end
    chk(cpso_word_t'(clk_per), cpso_word_t'(PER));
    rd(`CPSO_WDATA_OFF, v);
    chk(v & 32'h00000100, 32'h00000000);
    wr(`CPSO_CMD_OFF, 32'h00000000);
    complete_run();
  end
endmodule // cpso_top_tb

// ===== hdl/cpso_defines.svh
/*
  Offsets, field positions, reset values and timing counts of the
  configuration EEPROM serial interface.
  Assumes inclusion by bare name from files that need these constants.
*/
`ifndef CPSO_DEFINES_SVH
`define CPSO_DEFINES_SVH

`define CPSO_CMD_OFF 8'h00
`define CPSO_WDATA_OFF 8'h04

`define CPSO_BIT_WBUSY 3
`define CPSO_BIT_ACK 6
`define CPSO_BIT_EN 7
`define CPSO_BIT_OVR 8
`define CPSO_BIT_CLKF 9
`define CPSO_BIT_DATF 10
`define CPSO_BIT_DIN 11
`define CPSO_USED_MSB 11
`define CPSO_BIT_FULL 8

`define CPSO_EN_RST 1'b0
`define CPSO_OVR_RST 1'b0
`define CPSO_CLKF_RST 1'b0
`define CPSO_DATF_RST 1'b0
`define CPSO_ACK_RST 1'b1

`define CPSO_SYS_CLK_KHZ 40000
`define CPSO_BIT_CLK_KHZ 393
`define CPSO_TICK_CYCLES (`CPSO_SYS_CLK_KHZ / `CPSO_BIT_CLK_KHZ)
`define CPSO_PHASES 4
`define CPSO_BIT_SLOTS 9
`define CPSO_FIFO_DEPTH 4
`define CPSO_FIFO_WIDTH 8

`endif

// ===== hdl/cpso_fifo.sv
/*
  Small synchronous FIFO with valid and ready on both sides.
  Assumes one clock for both sides and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module cpso_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic push;
  logic pop;

  assign in_ready = (wr_ptr_q[AW-1:0] != rd_ptr_q[AW-1:0]) || (wr_ptr_q[AW] == rd_ptr_q[AW]);
  assign out_valid = (wr_ptr_q != rd_ptr_q);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_ptr_q[AW-1:0]];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_q <= '0;
    end else if (push) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_ptr_q <= '0;
    end else if (pop) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end
endmodule // cpso_fifo

// ===== hdl/cpso_pkg.sv
/*
  Types shared by the configuration EEPROM serial interface files.
  Assumes nothing of its surroundings.
*/
package cpso_pkg;
  typedef enum logic [1:0] {
    CPSO_IDLE,
    CPSO_SHIFT,
    CPSO_DONE
  } cpso_state_e;
  typedef logic [7:0] cpso_addr_t;
  typedef logic [31:0] cpso_word_t;
  typedef logic [7:0] cpso_byte_t;
endpackage

// ===== hdl/cpso_top.sv
/*
  Command register override bits and byte engine of the configuration
  EEPROM serial interface: manual line control, line readback, bit timing
  and acknowledged byte writes fed through a small FIFO.
  Assumes a register master on sys_clk and an external pull-up on the
  serial data line, which is released whenever the output enable is low.
*/
`timescale 1ns/1ps
`include "cpso_defines.svh"

// Overview of operation
// - Override bit stops automatic sequencing and hands both lines to software; reads back.
// - Under override the clock line follows the clock-force bit, which reads back.
// - Under override the data line follows the written data-force bit.
// - Reading the data-force bit returns the live data output level.
// - Synchronised data input level reads on a status bit; software writes zero.
// - Bits twelve to thirty-one read zero; software writes zero.
// - The serial engine runs from a derived bit clock near 393 kHz.
// - Each address or data bit takes exactly four bit-clock cycles.
// - Each byte is eight information bits then one acknowledge slot.
// - Busy of the acknowledged byte write clears when the byte has been sent.
module cpso_top (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire cpso_pkg::cpso_addr_t reg_addr,
  input wire cpso_pkg::cpso_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output cpso_pkg::cpso_word_t reg_rdata,
  input wire logic prom_data_in,
  output logic prom_clock_line,
  output logic prom_data_out,
  output logic prom_data_oe,
  output logic prom_access_enable
);
  import cpso_pkg::*;

  localparam int TICK_CYCLES = `CPSO_TICK_CYCLES;
  localparam int PHASES = `CPSO_PHASES;
  localparam int BIT_SLOTS = `CPSO_BIT_SLOTS;

  cpso_state_e state_q;
  logic [6:0] tick_cnt_q;
  logic tick_q;
  logic [1:0] phase_q;
  logic [3:0] bit_idx_q;
  cpso_byte_t shift_q;
  logic din_s1_q;
  logic din_s2_q;
  logic en_q;
  logic ovr_q;
  logic clkf_q;
  logic datf_q;
  logic wbusy_q;
  logic ack_q;
  cpso_byte_t wdata_q;
  cpso_word_t rdata_q;
  logic clk_line_q;
  logic dout_q;
  logic doe_q;
  logic cmd_wr;
  logic data_wr;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  cpso_byte_t fifo_out_data;
  logic step;
  logic bit_end;
  logic eng_clk;
  logic eng_oe;

  assign cmd_wr = reg_wr && (reg_addr == `CPSO_CMD_OFF);
  assign data_wr = reg_wr && (reg_addr == `CPSO_WDATA_OFF);

  // A step is one bit-clock cycle of the engine; none happen under override.
  assign step = tick_q && !ovr_q;
  assign bit_end = step && (phase_q == 2'(PHASES - 1));

  // The engine only takes a byte when the host has asked for one and enabled access.
  assign fifo_out_ready = (state_q == CPSO_IDLE) && wbusy_q && en_q && !ovr_q;

  cpso_fifo #(
    .WIDTH(`CPSO_FIFO_WIDTH),
    .DEPTH(`CPSO_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(data_wr),
    .in_ready(fifo_in_ready),
    .in_data(reg_wdata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      din_s1_q <= 1'b1;
      din_s2_q <= 1'b1;
    end else begin
      din_s1_q <= prom_data_in;
      din_s2_q <= din_s1_q;
    end
  end

  // Control bits are plain host-clock registers.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      en_q <= `CPSO_EN_RST;
      ovr_q <= `CPSO_OVR_RST;
      clkf_q <= `CPSO_CLKF_RST;
      datf_q <= `CPSO_DATF_RST;
    end else if (cmd_wr) begin
      en_q <= reg_wdata[`CPSO_BIT_EN];
      ovr_q <= reg_wdata[`CPSO_BIT_OVR];
      clkf_q <= reg_wdata[`CPSO_BIT_CLKF];
      datf_q <= reg_wdata[`CPSO_BIT_DATF];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wdata_q <= 8'h00;
    end else if (data_wr && fifo_in_ready) begin
      wdata_q <= reg_wdata[7:0];
    end
  end

  // A new command in the finishing cycle wins over the clear, so no command is lost.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wbusy_q <= 1'b0;
    end else if (cmd_wr && reg_wdata[`CPSO_BIT_WBUSY]) begin
      wbusy_q <= 1'b1;
    end else if ((state_q == CPSO_DONE) && !ovr_q) begin
      wbusy_q <= 1'b0;
    end
  end

  // Bit-clock divider, frozen under override so the sequence resumes where it stopped.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_q <= 7'h00;
      tick_q <= 1'b0;
    end else if (ovr_q) begin
      tick_q <= 1'b0;
    end else if (tick_cnt_q == 7'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= 7'h00;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 7'h01;
      tick_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= CPSO_IDLE;
    end else begin
      case (state_q)
        CPSO_IDLE: begin
          if (fifo_out_ready && fifo_out_valid) begin
            state_q <= CPSO_SHIFT;
          end
        end
        CPSO_SHIFT: begin
          if (bit_end && (bit_idx_q == 4'(BIT_SLOTS - 1))) begin
            state_q <= CPSO_DONE;
          end
        end
        CPSO_DONE: begin
          if (!ovr_q) begin
            state_q <= CPSO_IDLE;
          end
        end
        default: begin
          state_q <= CPSO_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= 2'h0;
    end else if (state_q != CPSO_SHIFT) begin
      phase_q <= 2'h0;
    end else if (step) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bit_idx_q <= 4'h0;
    end else if (state_q != CPSO_SHIFT) begin
      bit_idx_q <= 4'h0;
    end else if (bit_end) begin
      bit_idx_q <= bit_idx_q + 4'h1;
    end
  end

  // Most significant bit first; the byte is taken from the FIFO as the engine starts.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      shift_q <= 8'h00;
    end else if (fifo_out_ready && fifo_out_valid) begin
      shift_q <= fifo_out_data;
    end else if (bit_end) begin
      shift_q <= {shift_q[6:0], 1'b0};
    end
  end

  // The acknowledge is sampled on the last host cycle of the high clock of the ninth slot, just before it falls.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= `CPSO_ACK_RST;
    end else if (step && (state_q == CPSO_SHIFT) && (phase_q == 2'h2)
                 && (bit_idx_q == 4'(BIT_SLOTS - 1))) begin
      ack_q <= din_s2_q;
    end
  end

  // Clock is high in the two middle phases of each bit; data is set while it is low.
  assign eng_clk = (state_q == CPSO_SHIFT) && (phase_q == 2'h1 || phase_q == 2'h2);
  assign eng_oe = (state_q == CPSO_SHIFT) && (bit_idx_q < 4'(BIT_SLOTS - 1));

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clk_line_q <= 1'b0;
      dout_q <= 1'b1;
      doe_q <= 1'b0;
    end else if (ovr_q) begin
      clk_line_q <= clkf_q;
      dout_q <= datf_q;
      doe_q <= 1'b1;
    end else begin
      clk_line_q <= eng_clk;
      dout_q <= eng_oe ? shift_q[7] : 1'b1;
      doe_q <= eng_oe;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h00000000;
    end else if (reg_rd && (reg_addr == `CPSO_CMD_OFF)) begin
      rdata_q <= 32'h00000000;
      rdata_q[`CPSO_BIT_WBUSY] <= wbusy_q;
      rdata_q[`CPSO_BIT_ACK] <= ack_q;
      rdata_q[`CPSO_BIT_EN] <= en_q;
      rdata_q[`CPSO_BIT_OVR] <= ovr_q;
      rdata_q[`CPSO_BIT_CLKF] <= clkf_q;
      rdata_q[`CPSO_BIT_DATF] <= dout_q;
      rdata_q[`CPSO_BIT_DIN] <= din_s2_q;
    end else if (reg_rd && (reg_addr == `CPSO_WDATA_OFF)) begin
      rdata_q <= {23'h000000, !fifo_in_ready, wdata_q};
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign reg_rdata = rdata_q;
  assign prom_clock_line = clk_line_q;
  assign prom_data_out = dout_q;
  assign prom_data_oe = doe_q;
  assign prom_access_enable = en_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence last_slot_end_s;
    (state_q == CPSO_SHIFT) && bit_end && (bit_idx_q == 4'h8);
  endsequence

  sequence busy_drop_s;
    (state_q == CPSO_DONE) ##1 (state_q == CPSO_IDLE);
  endsequence

  // Two engine-driven cycles with the clock high; the EEPROM samples data in this window.
  sequence engine_high_s;
    !ovr_q ##1 (!ovr_q && prom_clock_line) ##1 prom_clock_line;
  endsequence

  override_clock_a: assert property (ovr_q |=> prom_clock_line == $past(clkf_q))
    else $error("Clock line does not follow the clock-force bit.");

  override_data_a: assert property (ovr_q
    |=> prom_data_out == $past(datf_q) && prom_data_oe)
    else $error("Data line does not follow the data-force bit.");

  override_freeze_a: assert property (ovr_q && $past(ovr_q)
    |-> $stable(tick_cnt_q) && $stable(phase_q) && $stable(state_q))
    else $error("Engine advanced under override.");

  reserved_zero_a: assert property (reg_rd |=> reg_rdata[31:12] == 20'h00000)
    else $error("Unused register bits read non-zero.");

  data_level_rd_a: assert property (reg_rd && reg_addr == `CPSO_CMD_OFF
    |=> reg_rdata[`CPSO_BIT_DATF] == $past(dout_q))
    else $error("Data-force read does not show the output level.");

  data_input_rd_a: assert property (reg_rd && reg_addr == `CPSO_CMD_OFF
    |=> reg_rdata[`CPSO_BIT_DIN] == $past(din_s2_q))
    else $error("Input status bit does not show the sampled input.");

  tick_spacing_a: assert property (tick_q |=> !tick_q [*8])
    else $error("Bit-clock ticks come too close together.");

  phase_on_tick_a: assert property ((state_q == CPSO_SHIFT)
    && ($past(state_q) == CPSO_SHIFT) && $changed(phase_q) |-> $past(step))
    else $error("Bit phase moved without a bit-clock step.");

  nine_slots_a: assert property (last_slot_end_s |=> state_q == CPSO_DONE)
    else $error("Byte did not end after nine slots.");

  busy_clear_a: assert property (busy_drop_s
    |-> !wbusy_q || ($past(cmd_wr) && $past(reg_wdata[`CPSO_BIT_WBUSY])))
    else $error("Write busy not cleared after the byte.");

  reset_values_a: assert property ($rose(rstn) |-> !ovr_q && !clkf_q && !datf_q)
    else $error("Override bits not zero after reset.");

  override_read_a: assert property (reg_rd && reg_addr == `CPSO_CMD_OFF
    |=> reg_rdata[`CPSO_BIT_OVR] == $past(ovr_q))
    else $error("Override bit does not read back.");

  clock_force_read_a: assert property (reg_rd && reg_addr == `CPSO_CMD_OFF
    |=> reg_rdata[`CPSO_BIT_CLKF] == $past(clkf_q))
    else $error("Clock-force bit does not read back.");

  enable_read_a: assert property (reg_rd && reg_addr == `CPSO_CMD_OFF
    |=> reg_rdata[`CPSO_BIT_EN] == $past(en_q))
    else $error("Access enable bit does not read back.");

  busy_set_a: assert property (cmd_wr && reg_wdata[`CPSO_BIT_WBUSY] |=> wbusy_q)
    else $error("Write busy not raised by the command.");

  idle_release_a: assert property ((state_q != CPSO_SHIFT) && !ovr_q
    |=> !prom_data_oe && prom_data_out)
    else $error("Data line not released while the engine is idle.");

  ack_release_a: assert property ((state_q == CPSO_SHIFT)
    && (bit_idx_q == 4'h8) && !ovr_q |=> !prom_data_oe)
    else $error("Data line not released for the acknowledge slot.");

  data_hold_a: assert property (engine_high_s
    |-> $stable(prom_data_out) && $stable(prom_data_oe))
    else $error("Data moved while the clock was high.");

  bit_advance_a: assert property ((state_q == CPSO_SHIFT)
    && ($past(state_q) == CPSO_SHIFT) && $changed(bit_idx_q) |-> $past(phase_q) == 2'h3)
    else $error("Bit slot ended before its fourth phase.");
endmodule // cpso_top
